// file: spcr_pkg.sv
// Package with register map, field positions and reset values
package spcr_pkg;
	localparam int SPCR_ADDR_W = 21;
	localparam logic [20:0] SPCR_CTRL_ADDR = 21'h1F0000;
	localparam logic [20:0] SPCR_ANSTAT_ADDR = 21'h1F8002;
	localparam int SPCR_BIT_SRST = 15;
	localparam int SPCR_BIT_LOOP = 14;
	localparam int SPCR_BIT_SPD_LO = 13;
	localparam int SPCR_BIT_ANEN = 12;
	localparam int SPCR_BIT_PDN = 11;
	localparam int SPCR_BIT_ANRST = 9;
	localparam int SPCR_BIT_DUP = 8;
	localparam int SPCR_BIT_SPD_HI = 6;
	localparam logic [15:0] SPCR_CTRL_RESET = 16'h1140;
	localparam logic [15:0] SPCR_CTRL_RW_MASK = 16'h7940;
	localparam logic [1:0] SPCR_SPD_10 = 2'h0;
	localparam logic [1:0] SPCR_SPD_100 = 2'h1;
	localparam logic [1:0] SPCR_SPD_1000 = 2'h2;
	localparam logic [1:0] SPCR_SPD_RSVD = 2'h3;
	localparam int SPCR_ST_SPD_LSB = 2;
	localparam int SPCR_ST_DUP = 1;
	localparam int SPCR_ST_DONE = 0;
endpackage

// file: spcr_ctl_if.sv
// Interface carrying decoded control levels to the pulse stage
`timescale 1ns/1ps
interface spcr_ctl_if;
	logic srst_req;
	logic an_req;
	logic srst_pulse;
	logic an_pulse;
	modport src (output srst_req, output an_req, input srst_pulse, input an_pulse);
	modport dst (input srst_req, input an_req, output srst_pulse, output an_pulse);
endinterface

// file: spcr_pulse.sv
// Registered pulses for self-clearing command bits, one cycle after the request and as long as it
`timescale 1ns/1ps
module spcr_pulse
	import spcr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	spcr_ctl_if.dst ctl
);
	typedef struct packed {
		logic srst;
		logic an;
	} spcr_pulse_s;
	spcr_pulse_s st_reg;
	spcr_pulse_s st_next;

	always_comb
	begin
		st_next.srst = ctl.srst_req;
		st_next.an = ctl.an_req;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign ctl.srst_pulse = st_reg.srst;
	assign ctl.an_pulse = st_reg.an;
endmodule

// file: spcr_top.sv
// SGMII port control register with soft reset, loopback, speed, AN and power-down
`timescale 1ns/1ps
module spcr_top
	import spcr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [20:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_rdata,
	output logic o_rvalid,
	input wire logic i_sgmii_mode,
	input wire logic i_chip_pdn,
	input wire logic i_an_done,
	input wire logic [1:0] i_an_speed,
	input wire logic i_an_duplex,
	output logic o_block_rst,
	output logic o_an_restart,
	output logic o_an_enable,
	output logic o_loopback,
	output logic [1:0] o_speed,
	output logic o_full_duplex,
	output logic o_rx_en,
	output logic o_tx_en,
	output logic o_clk_en
);
	typedef struct packed {
		logic loop;
		logic spd_lo;
		logic anen;
		logic pdn;
		logic dup;
		logic spd_hi;
		logic [15:0] rdata;
		logic rvalid;
	} spcr_state_s;
	spcr_state_s st_reg;
	spcr_state_s st_next;
	spcr_ctl_if ctl ();
	logic wr_ctrl;
	logic [15:0] ctrl_view;
	logic [15:0] stat_view;

	spcr_pulse u_pulse (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.ctl(ctl)
	);

	assign wr_ctrl = i_wr && (i_addr == SPCR_CTRL_ADDR);
	assign ctl.srst_req = wr_ctrl && i_wdata[SPCR_BIT_SRST];
	assign ctl.an_req = (wr_ctrl && i_wdata[SPCR_BIT_ANRST]) && !ctl.srst_req;

	always_comb
	begin
		ctrl_view = '0;
		ctrl_view[SPCR_BIT_LOOP] = st_reg.loop;
		ctrl_view[SPCR_BIT_SPD_LO] = st_reg.spd_lo;
		ctrl_view[SPCR_BIT_ANEN] = st_reg.anen;
		ctrl_view[SPCR_BIT_PDN] = st_reg.pdn;
		ctrl_view[SPCR_BIT_DUP] = st_reg.dup;
		ctrl_view[SPCR_BIT_SPD_HI] = st_reg.spd_hi;
	end

	always_comb
	begin
		stat_view = '0;
		stat_view[SPCR_ST_SPD_LSB +: 2] = i_an_speed;
		stat_view[SPCR_ST_DUP] = i_an_duplex;
		stat_view[SPCR_ST_DONE] = i_an_done;
	end

	always_comb
	begin
		st_next = st_reg;
		st_next.rvalid = i_rd;
		if (i_rd)
		begin
			if (i_addr == SPCR_CTRL_ADDR)
				st_next.rdata = ctrl_view;
			else if (i_addr == SPCR_ANSTAT_ADDR)
				st_next.rdata = stat_view;
			else
				st_next.rdata = '0;
		end
		if (ctl.srst_pulse)
		begin
			st_next.loop = SPCR_CTRL_RESET[SPCR_BIT_LOOP];
			st_next.spd_lo = SPCR_CTRL_RESET[SPCR_BIT_SPD_LO];
			st_next.anen = SPCR_CTRL_RESET[SPCR_BIT_ANEN];
			st_next.pdn = SPCR_CTRL_RESET[SPCR_BIT_PDN];
			st_next.dup = SPCR_CTRL_RESET[SPCR_BIT_DUP];
			st_next.spd_hi = SPCR_CTRL_RESET[SPCR_BIT_SPD_HI];
		end
		else if (wr_ctrl && !i_wdata[SPCR_BIT_SRST])
		begin
			st_next.loop = i_wdata[SPCR_BIT_LOOP];
			st_next.spd_lo = i_wdata[SPCR_BIT_SPD_LO];
			st_next.anen = i_wdata[SPCR_BIT_ANEN];
			st_next.pdn = i_wdata[SPCR_BIT_PDN];
			st_next.dup = i_wdata[SPCR_BIT_DUP];
			st_next.spd_hi = i_wdata[SPCR_BIT_SPD_HI];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_reg.loop <= SPCR_CTRL_RESET[SPCR_BIT_LOOP];
			st_reg.spd_lo <= SPCR_CTRL_RESET[SPCR_BIT_SPD_LO];
			st_reg.anen <= SPCR_CTRL_RESET[SPCR_BIT_ANEN];
			st_reg.pdn <= SPCR_CTRL_RESET[SPCR_BIT_PDN];
			st_reg.dup <= SPCR_CTRL_RESET[SPCR_BIT_DUP];
			st_reg.spd_hi <= SPCR_CTRL_RESET[SPCR_BIT_SPD_HI];
			st_reg.rdata <= '0;
			st_reg.rvalid <= 1'b0;
		end
		else
			st_reg <= st_next;
	end

	assign o_rdata = st_reg.rdata;
	assign o_rvalid = st_reg.rvalid;
	assign o_block_rst = ctl.srst_pulse;
	assign o_an_restart = ctl.an_pulse && !st_reg.pdn;
	assign o_an_enable = st_reg.anen && i_sgmii_mode;
	assign o_loopback = st_reg.loop;
	assign o_speed = {st_reg.spd_hi, st_reg.spd_lo};
	assign o_full_duplex = st_reg.dup;
	assign o_rx_en = !st_reg.pdn;
	assign o_tx_en = !st_reg.pdn;
	assign o_clk_en = !st_reg.pdn;

	property p_srst_self_clear;
		@(posedge i_clk) disable iff (!i_rst_n)
		ctl.srst_req |=> o_block_rst ##1 (!o_block_rst || $past(ctl.srst_req));
	endproperty
	a_srst_self_clear: assert property (p_srst_self_clear) else $error("soft reset not one pulse");

	property p_srst_defaults;
		@(posedge i_clk) disable iff (!i_rst_n)
		o_block_rst |=> (o_speed == SPCR_SPD_1000 && o_full_duplex && !o_loopback && o_rx_en);
	endproperty
	a_srst_defaults: assert property (p_srst_defaults) else $error("defaults not restored");

	property p_loop_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ctrl && !i_wdata[SPCR_BIT_SRST] && !ctl.srst_pulse) |=>
			(o_loopback == $past(i_wdata[SPCR_BIT_LOOP]));
	endproperty
	a_loop_write: assert property (p_loop_write) else $error("loopback not written");

	property p_speed_write;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ctrl && !i_wdata[SPCR_BIT_SRST] && !ctl.srst_pulse) |=>
			(o_speed == {$past(i_wdata[SPCR_BIT_SPD_HI]), $past(i_wdata[SPCR_BIT_SPD_LO])});
	endproperty
	a_speed_write: assert property (p_speed_write) else $error("speed field wrong");

	property p_an_gate;
		@(posedge i_clk) disable iff (!i_rst_n)
		!i_sgmii_mode |-> !o_an_enable;
	endproperty
	a_an_gate: assert property (p_an_gate) else $error("AN enabled outside SGMII");

	property p_pdn_paths;
		@(posedge i_clk) disable iff (!i_rst_n)
		(wr_ctrl && !i_wdata[SPCR_BIT_SRST] && i_wdata[SPCR_BIT_PDN] && !ctl.srst_pulse) |=>
			(!o_rx_en && !o_tx_en && !o_clk_en);
	endproperty
	a_pdn_paths: assert property (p_pdn_paths) else $error("power-down not applied");

	sequence s_an_write;
		wr_ctrl && i_wdata[SPCR_BIT_ANRST] && !i_wdata[SPCR_BIT_SRST] && !st_reg.pdn;
	endsequence
	sequence s_an_pulse;
		o_an_restart ##1 !o_an_restart;
	endsequence
	property p_an_restart;
		@(posedge i_clk) disable iff (!i_rst_n)
		s_an_write ##1 (!wr_ctrl && !st_reg.pdn) |-> s_an_pulse;
	endproperty
	a_an_restart: assert property (p_an_restart) else $error("AN restart pulse wrong");

	property p_rsvd_zero;
		@(posedge i_clk) disable iff (!i_rst_n)
		o_rvalid && $past(i_addr) == SPCR_CTRL_ADDR |->
			((o_rdata & ~SPCR_CTRL_RW_MASK) == 16'h0000);
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

	property p_status_read;
		@(posedge i_clk) disable iff (!i_rst_n)
		(i_rd && i_addr == SPCR_ANSTAT_ADDR) |=>
			(o_rvalid && o_rdata[SPCR_ST_SPD_LSB +: 2] == $past(i_an_speed));
	endproperty
	a_status_read: assert property (p_status_read) else $error("AN status not reported");

	property p_pdn_indep;
		@(posedge i_clk) disable iff (!i_rst_n)
		($changed(i_chip_pdn) && !$past(wr_ctrl) && !$past(ctl.srst_pulse)) |->
			($stable(o_clk_en) && $stable(o_rx_en) && $stable(o_tx_en));
	endproperty
	a_pdn_indep: assert property (p_pdn_indep) else $error("chip power-down reached port");

	property p_srst_anen;
		@(posedge i_clk) disable iff (!i_rst_n)
		o_block_rst |=> (o_an_enable == i_sgmii_mode);
	endproperty
	a_srst_anen: assert property (p_srst_anen) else $error("AN enable default lost");
endmodule

// file: spcr_an_partner.sv
// Link partner model giving negotiation results
`timescale 1ns/1ps
module spcr_an_partner
#(
	parameter int DELAY = 6,
	parameter logic [1:0] SPD = 2'h1
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_restart,
	output logic o_done,
	output logic [1:0] o_speed,
	output logic o_duplex
);
	int cnt;
	always @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n || i_restart)
		begin
			cnt <= DELAY;
			o_done <= 1'b0;
			o_speed <= ~SPD;
			o_duplex <= 1'b1;
		end
		else if (cnt > 0)
			cnt <= cnt - 1;
		else
		begin
			o_done <= 1'b1;
			o_speed <= SPD;
			o_duplex <= 1'b0;
		end
	end
endmodule

// file: sgmii_port_control_register_tb.sv
// Testbench for the SGMII port control register
`timescale 1ns/1ps
module sgmii_port_control_register_tb;
	import spcr_pkg::*;
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_sgmii_mode = 1, i_chip_pdn = 0;
	logic [20:0] i_addr = '0;
	logic [15:0] i_wdata = '0;
	logic [15:0] o_rdata;
	logic [1:0] o_speed, an_speed;
	logic o_rvalid, o_block_rst, o_an_restart, o_an_enable, o_loopback, o_full_duplex;
	logic o_rx_en, o_tx_en, o_clk_en, an_done, an_dup;
	int err_count = 0, n_checks = 0, n_rst = 0, n_anr = 0, prev;
	always #2.5 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		n_rst <= n_rst + int'(o_block_rst === 1'b1);
		n_anr <= n_anr + int'(o_an_restart === 1'b1);
	end
	spcr_top u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
		.i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
		.i_sgmii_mode(i_sgmii_mode), .i_chip_pdn(i_chip_pdn), .i_an_done(an_done),
		.i_an_speed(an_speed), .i_an_duplex(an_dup), .o_block_rst(o_block_rst),
		.o_an_restart(o_an_restart), .o_an_enable(o_an_enable), .o_loopback(o_loopback),
		.o_speed(o_speed), .o_full_duplex(o_full_duplex), .o_rx_en(o_rx_en),
		.o_tx_en(o_tx_en), .o_clk_en(o_clk_en));
	spcr_an_partner #(.DELAY(6), .SPD(2'h1)) u_partner (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_restart(o_an_restart), .o_done(an_done), .o_speed(an_speed), .o_duplex(an_dup));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [20:0] a, input logic [15:0] d);
		@(negedge i_clk);
		i_addr = a;
		i_wdata = d;
		i_wr = 1;
		@(negedge i_clk);
		i_wr = 0;
	endtask
	task rd(input logic [20:0] a, input logic [15:0] exp);
		@(negedge i_clk);
		i_addr = a;
		i_rd = 1;
		@(negedge i_clk);
		i_rd = 0;
		chk({15'h0, o_rvalid}, 16'h0001);
		chk(o_rdata, exp);
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(negedge i_clk);
		i_rst_n = 1;
		rd(SPCR_CTRL_ADDR, 16'h1140);
		chk({14'h0, o_speed}, 16'h0002);
		chk({15'h0, o_an_enable}, 16'h0001);
		$display("test reset done");
		wr(SPCR_CTRL_ADDR, 16'h7100);
		chk({13'h0, o_loopback, o_speed}, 16'h0005);
		rd(SPCR_CTRL_ADDR, 16'h7100);
		i_sgmii_mode = 0;
		#1 chk({15'h0, o_an_enable}, 16'h0000);
		@(negedge i_clk);
		i_sgmii_mode = 1;
		for (int s = 0; s < 4; s++)
		begin
			wr(SPCR_CTRL_ADDR, {2'h0, s[0], 6'h0, s[1], 6'h0});
			chk({14'h0, o_speed}, {14'h0, s[1], s[0]});
		end
		$display("test fields done");
		prev = n_anr;
		wr(SPCR_CTRL_ADDR, 16'h06BF);
		rd(SPCR_CTRL_ADDR, 16'h0000);
		chk(16'(n_anr - prev), 16'h0001);
		for (int i = 0; i < 20 && an_done !== 1'b1; i++)
			@(negedge i_clk);
		if (an_done !== 1'b1)
		begin
			err_count++;
			$display("[ERR] %0t negotiation never completed", $time);
		end
		rd(SPCR_ANSTAT_ADDR, 16'h0005);
		rd(21'h1F0001, 16'h0000);
		wr(SPCR_CTRL_ADDR, 16'h3000);
		chk({13'h0, o_full_duplex, o_speed}, 16'h0001);
		$display("test negotiation done");
		i_chip_pdn = 1;
		wr(SPCR_CTRL_ADDR, 16'h0800);
		chk({13'h0, o_rx_en, o_tx_en, o_clk_en}, 16'h0000);
		prev = n_anr;
		wr(SPCR_CTRL_ADDR, 16'h0A00);
		rd(SPCR_CTRL_ADDR, 16'h0800);
		chk(16'(n_anr - prev), 16'h0000);
		i_chip_pdn = 0;
		#1 chk({13'h0, o_rx_en, o_tx_en, o_clk_en}, 16'h0000);
		wr(SPCR_CTRL_ADDR, 16'h0000);
		chk({13'h0, o_rx_en, o_tx_en, o_clk_en}, 16'h0007);
		$display("test power-down done");
		prev = n_rst;
		wr(SPCR_CTRL_ADDR, 16'hFFFF);
		rd(SPCR_CTRL_ADDR, 16'h1140);
		chk(16'(n_rst - prev), 16'h0001);
		$display("test soft reset done");
		wrap_up;
	end
endmodule
